// [include/aoscr_pkg.sv]
// Constants, field positions and field codes of the aux output, converter and receiver control slice.
package aoscr_pkg;

    // ========================================================
    // Widths
    localparam int unsigned SAMP_W = 24;
    localparam int unsigned GAIN_W = 5;

    // ========================================================
    // Register addresses on the serial control port
    localparam logic [6:0] AUX_OUT_ADDR    = 7'h07;
    localparam logic [6:0] DELAY_MUTE_ADDR = 7'h08;
    localparam logic [6:0] RX_CFG1_ADDR    = 7'h09;
    localparam logic [6:0] RX_CFG2_ADDR    = 7'h0a;

    // ========================================================
    // Reset values and writable bits
    localparam logic [7:0] AUX_OUT_RESET    = 8'h00;
    localparam logic [7:0] DELAY_MUTE_RESET = 8'h00;
    localparam logic [7:0] RX_CFG1_RESET    = 8'h00;
    localparam logic [7:0] RX_CFG2_RESET    = 8'h00;
    localparam logic [7:0] AUX_OUT_MASK     = 8'h3f;
    localparam logic [7:0] RX_CFG2_MASK     = 8'hf3;

    // ========================================================
    // Field positions
    localparam int unsigned AUX_CLK_LSB      = 4;
    localparam int unsigned AUX_OUTPUT_WORD_SIZE_LSB     = 2;
    localparam int unsigned AUX_FMT_LSB      = 0;
    localparam int unsigned DM_MUTE_BIT      = 7;
    localparam int unsigned DM_DELAY_LSB     = 0;
    localparam int unsigned RC1_FALLBACK_BIT = 7;
    localparam int unsigned RC1_RATIO_LSB    = 5;
    localparam int unsigned RC1_DEEMPH_BIT   = 4;
    localparam int unsigned RC1_ERR_LSB      = 2;
    localparam int unsigned RC1_LOCK_LSB     = 0;
    localparam int unsigned RC2_HMUTE_BIT    = 7;
    localparam int unsigned RC2_PLLREF_BIT   = 6;
    localparam int unsigned RC2_PORTSEL_LSB  = 4;
    localparam int unsigned RC2_NONAUD_BIT   = 1;
    localparam int unsigned RC2_VALID_BIT    = 0;

    // ========================================================
    // Field codes
    localparam logic [1:0] OUTPUT_WORD_SIZE_24   = 2'h0;
    localparam logic [1:0] OUTPUT_WORD_SIZE_20   = 2'h1;
    localparam logic [1:0] OUTPUT_WORD_SIZE_18   = 2'h2;
    localparam logic [4:0] WORD_24   = 5'h18;
    localparam logic [4:0] WORD_20   = 5'h14;
    localparam logic [4:0] WORD_18   = 5'h12;
    localparam logic [4:0] WORD_16   = 5'h10;
    localparam logic [1:0] RATIO_128 = 2'h0;
    localparam logic [1:0] RATIO_256 = 2'h1;
    localparam logic [1:0] RATIO_512 = 2'h2;
    localparam logic [9:0] MULT_128  = 10'h080;
    localparam logic [9:0] MULT_256  = 10'h100;
    localparam logic [9:0] MULT_512  = 10'h200;
    localparam logic [9:0] MULT_NONE = 10'h000;
    localparam logic [1:0] ACT_NONE  = 2'h0;
    localparam logic [1:0] ACT_HOLD  = 2'h1;
    localparam logic [1:0] ACT_ZERO  = 2'h2;
    localparam logic [1:0] ACT_SOFT  = 2'h3;

    // ========================================================
    // Serial frame and soft mute ramp
    localparam logic [4:0] SPI_HDR_LAST  = 5'h07;
    localparam logic [4:0] SPI_DATA_LAST = 5'h0f;
    localparam logic [4:0] SPI_FIRST_OUT = 5'h08;
    localparam logic [4:0] SPI_DONE      = 5'h10;
    localparam logic [4:0] GAIN_MAX      = 5'h10;
    localparam logic [4:0] GAIN_ZERO     = 5'h00;

endpackage

// [include/aoscr_buf_if.sv]
// Valid/ready channel between the sample path and its two-entry buffer.
`timescale 1ns/10ps
interface aoscr_buf_if;
    logic                         in_valid;
    logic                         in_ready;
    logic [aoscr_pkg::SAMP_W-1:0] in_data;
    logic                         out_valid;
    logic                         out_ready;
    logic [aoscr_pkg::SAMP_W-1:0] out_data;

    modport buf_side  (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// [hdl/aoscr_buf.sv]
// Two-entry sample buffer with valid and ready on both sides.
`timescale 1ns/10ps
module aoscr_buf
(
    input wire logic       clk_i,
    input wire logic       nrst_i,
    aoscr_buf_if.buf_side  bus
);
    import aoscr_pkg::*;

    logic [SAMP_W-1:0] mem_reg [2];
    logic              wr_ptr_reg;
    logic              rd_ptr_reg;
    logic [1:0]        count_reg;
    logic              push;
    logic              pop;

    assign bus.in_ready  = (count_reg != 2'h2);
    assign bus.out_valid = (count_reg != 2'h0);
    assign bus.out_data  = mem_reg[rd_ptr_reg];
    assign push          = bus.in_valid & bus.in_ready;
    assign pop           = bus.out_valid & bus.out_ready;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem_reg[wr_ptr_reg] <= bus.in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop)
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // ========================================================
    // Checks
    buf_bound_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
        count_reg != 2'h3)
        else $error("Buffer count out of range.");

endmodule // aoscr_buf

// [hdl/aoscr_top.sv]
// Aux output port, converter delay and mute, and receiver control registers with sample path.
`timescale 1ns/10ps
module aoscr_top
(
    input  wire logic                         clk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         spi_sclk_i,
    input  wire logic                         spi_cs_n_i,
    input  wire logic                         spi_mosi_i,
    output wire logic                         spi_miso_o,
    output wire logic                         spi_miso_oe_o,
    input  wire logic                         pll_locked_i,
    input  wire logic                         cs_emphasis_i,
    input  wire logic                         rx_valid_i,
    output wire logic                         rx_ready_o,
    input  wire logic [aoscr_pkg::SAMP_W-1:0] rx_data_i,
    input  wire logic                         rx_error_i,
    input  wire logic                         rx_compressed_i,
    output wire logic                         aud_valid_o,
    input  wire logic                         aud_ready_i,
    output wire logic [aoscr_pkg::SAMP_W-1:0] aud_data_o,
    output wire logic [1:0]                   port_clock_origin_o,
    output wire logic [4:0]                   output_word_size_o,
    output wire logic [1:0]                   serial_framing_format_o,
    output wire logic [6:0]                   fir_extra_delay_o,
    output wire logic                         rx_clock_use_internal_clock_one_o,
    output wire logic [9:0]                   recovered_clock_ratio_o,
    output wire logic                         deemphasis_apply_o,
    output wire logic                         pll_ref_from_serial_port_o,
    output wire logic [1:0]                   pll_ref_port_select_o,
    output wire logic [aoscr_pkg::GAIN_W-1:0] converter_gain_o
);
    import aoscr_pkg::*;

    // ========================================================
    // Pin synchronisers
    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    logic cs_n_s1_reg, cs_n_s2_reg;
    logic mosi_s1_reg, mosi_s2_reg;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            cs_n_s1_reg <= 1'b1;
            cs_n_s2_reg <= 1'b1;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
        end
        else
        begin
            sclk_s1_reg <= spi_sclk_i;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            cs_n_s1_reg <= spi_cs_n_i;
            cs_n_s2_reg <= cs_n_s1_reg;
            mosi_s1_reg <= spi_mosi_i;
            mosi_s2_reg <= mosi_s1_reg;
        end
    end

    // ========================================================
    // Serial control port: 7-bit address, read flag, 8 data bits, MSB first
    logic [4:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [6:0] addr_reg;
    logic       rd_reg;
    logic [7:0] tx_reg;
    logic [7:0] aux_reg, dm_reg, rc1_reg, rc2_reg;
    logic       frame_on, sclk_rise, sclk_fall;
    logic       hdr_done, wr_en;
    logic [7:0] in_byte;

    function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] r0,
                                            input logic [7:0] r1, input logic [7:0] r2,
                                            input logic [7:0] r3);
        logic [7:0] v;
        v = 8'h00;
        if (a == AUX_OUT_ADDR) v = r0;
        else if (a == DELAY_MUTE_ADDR) v = r1;
        else if (a == RX_CFG1_ADDR) v = r2;
        else if (a == RX_CFG2_ADDR) v = r3;
        return v;
    endfunction

    assign frame_on      = ~cs_n_s2_reg;
    assign sclk_rise     = frame_on & sclk_s2_reg & ~sclk_s3_reg;
    assign sclk_fall     = frame_on & ~sclk_s2_reg & sclk_s3_reg;
    assign in_byte       = {shift_reg, mosi_s2_reg};
    assign hdr_done      = sclk_rise & (bit_cnt_reg == SPI_HDR_LAST);
    assign wr_en         = sclk_rise & (bit_cnt_reg == SPI_DATA_LAST) & ~rd_reg;
    assign spi_miso_oe_o = frame_on & rd_reg & (bit_cnt_reg >= SPI_FIRST_OUT);
    assign spi_miso_o    = tx_reg[7];

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i || !frame_on)
        begin
            bit_cnt_reg <= 5'h00;
            shift_reg   <= 7'h00;
            addr_reg    <= 7'h00;
            rd_reg      <= 1'b0;
            tx_reg      <= 8'h00;
        end
        else
        begin
            if (sclk_rise && bit_cnt_reg != SPI_DONE)
            begin
                shift_reg   <= in_byte[6:0];
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
            if (hdr_done)
            begin
                addr_reg <= in_byte[7:1];
                rd_reg   <= in_byte[0];
                tx_reg   <= reg_read(in_byte[7:1], aux_reg, dm_reg, rc1_reg, rc2_reg);
            end
            else if (sclk_fall && bit_cnt_reg > SPI_FIRST_OUT)
            begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // ========================================================
    // Control registers
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            aux_reg <= AUX_OUT_RESET;
            dm_reg  <= DELAY_MUTE_RESET;
            rc1_reg <= RX_CFG1_RESET;
            rc2_reg <= RX_CFG2_RESET;
        end
        else if (wr_en)
        begin
            if (addr_reg == AUX_OUT_ADDR) aux_reg <= in_byte & AUX_OUT_MASK;
            else if (addr_reg == DELAY_MUTE_ADDR) dm_reg <= in_byte;
            else if (addr_reg == RX_CFG1_ADDR) rc1_reg <= in_byte;
            else if (addr_reg == RX_CFG2_ADDR) rc2_reg <= in_byte & RX_CFG2_MASK;
        end
    end

    // ========================================================
    // Decoded configuration
    logic [1:0] output_word_size, ratio, err_act, lock_act;
    logic       soft_silence, hard_silence, validity_gate, nonaudio_gate;

    assign output_word_size          = aux_reg[AUX_OUTPUT_WORD_SIZE_LSB +: 2];
    assign ratio         = rc1_reg[RC1_RATIO_LSB +: 2];
    assign err_act       = rc1_reg[RC1_ERR_LSB +: 2];
    assign lock_act      = rc1_reg[RC1_LOCK_LSB +: 2];
    assign soft_silence  = dm_reg[DM_MUTE_BIT];
    assign hard_silence  = rc2_reg[RC2_HMUTE_BIT];
    assign nonaudio_gate = rc2_reg[RC2_NONAUD_BIT];
    assign validity_gate = rc2_reg[RC2_VALID_BIT];

    assign port_clock_origin_o        = aux_reg[AUX_CLK_LSB +: 2];
    assign serial_framing_format_o    = aux_reg[AUX_FMT_LSB +: 2];
    assign output_word_size_o         = (output_word_size == OUTPUT_WORD_SIZE_24) ? WORD_24 :
                                        (output_word_size == OUTPUT_WORD_SIZE_20) ? WORD_20 :
                                        (output_word_size == OUTPUT_WORD_SIZE_18) ? WORD_18 : WORD_16;
    assign fir_extra_delay_o          = dm_reg[DM_DELAY_LSB +: 7];
    assign rx_clock_use_internal_clock_one_o       = rc1_reg[RC1_FALLBACK_BIT] & ~pll_locked_i;
    assign recovered_clock_ratio_o    = (ratio == RATIO_128) ? MULT_128 :
                                        (ratio == RATIO_256) ? MULT_256 :
                                        (ratio == RATIO_512) ? MULT_512 : MULT_NONE;
    assign deemphasis_apply_o         = rc1_reg[RC1_DEEMPH_BIT] & cs_emphasis_i;
    assign pll_ref_from_serial_port_o = rc2_reg[RC2_PLLREF_BIT];
    assign pll_ref_port_select_o      = rc2_reg[RC2_PORTSEL_LSB +: 2];

    // ========================================================
    // Receiver sample path
    aoscr_buf_if buf_if ();

    aoscr_buf u_buf
    (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .bus    (buf_if.buf_side)
    );

    logic [SAMP_W-1:0] last_good_reg;
    logic [GAIN_W-1:0] gain_reg;
    logic              unlocked, gate_block, sel_zero, sel_hold, ramp_down, push;
    logic [SAMP_W-1:0] pick;

    function automatic logic [SAMP_W-1:0] apply_gain(input logic [SAMP_W-1:0] s,
                                                      input logic [GAIN_W-1:0] g);
        logic signed [SAMP_W+GAIN_W:0] p;
        p = $signed(s) * $signed({1'b0, g});
        return p[SAMP_W+3:4];
    endfunction

    assign unlocked   = ~pll_locked_i;
    assign gate_block = validity_gate | nonaudio_gate | rx_compressed_i;
    assign sel_zero   = hard_silence
                      | (rx_error_i & err_act == ACT_ZERO)
                      | (unlocked & lock_act == ACT_ZERO);
    assign sel_hold   = (rx_error_i & err_act == ACT_HOLD)
                      | (unlocked & (lock_act == ACT_HOLD | lock_act == ACT_SOFT));
    assign pick       = sel_zero ? '0 : (sel_hold ? last_good_reg : rx_data_i);
    assign ramp_down  = soft_silence | (unlocked & lock_act == ACT_SOFT);

    assign buf_if.in_valid  = rx_valid_i & ~gate_block;
    assign buf_if.in_data   = apply_gain(pick, gain_reg);
    assign buf_if.out_ready = aud_ready_i;
    assign rx_ready_o       = gate_block | buf_if.in_ready;
    assign aud_valid_o      = buf_if.out_valid;
    assign aud_data_o       = buf_if.out_data;
    assign converter_gain_o = gain_reg;
    assign push             = buf_if.in_valid & buf_if.in_ready;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            last_good_reg <= '0;
            gain_reg      <= GAIN_MAX;
        end
        else if (push)
        begin
            if (!rx_error_i && pll_locked_i)
            begin
                last_good_reg <= rx_data_i;
            end
            if (ramp_down && gain_reg != GAIN_ZERO)
            begin
                gain_reg <= gain_reg - 5'h01;
            end
            else if (!ramp_down && gain_reg != GAIN_MAX)
            begin
                gain_reg <= gain_reg + 5'h01;
            end
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic [7:0] wr_byte_q;
    logic [6:0] wr_addr_q;

    always_ff @(posedge clk_i)
    begin
        wr_byte_q <= in_byte;
        wr_addr_q <= addr_reg;
    end

    sequence aux_write_s;
        wr_en && addr_reg == AUX_OUT_ADDR;
    endsequence

    sequence dm_write_s;
        wr_en && addr_reg == DELAY_MUTE_ADDR;
    endsequence

    clock_origin_a : assert property (aux_write_s |=> port_clock_origin_o == wr_byte_q[5:4])
        else $error("Clock origin does not follow the write.");
    word_size_a : assert property (aux_write_s ##1 (wr_byte_q[3:2] == 2'h3)
        |-> output_word_size_o == 5'h10)
        else $error("Word size code 11 is not 16 bits.");
    framing_a : assert property (aux_write_s |=> serial_framing_format_o == wr_byte_q[1:0])
        else $error("Framing format does not follow the write.");
    delay_write_a : assert property (dm_write_s |=> fir_extra_delay_o == wr_byte_q[6:0])
        else $error("Group delay does not follow the write.");
    mute_floor_a : assert property (push && gain_reg == 5'h00 |-> buf_if.in_data == '0)
        else $error("Muted gain passes audio.");
    ramp_step_a : assert property (push && ramp_down && gain_reg != 5'h00
        |=> gain_reg == $past(gain_reg) - 5'h01)
        else $error("Soft mute did not step down by one.");
    clk_fallback_a : assert property (rc1_reg[7] && !pll_locked_i |-> rx_clock_use_internal_clock_one_o)
        else $error("Unlocked fallback clock not chosen.");
    ratio_code_a : assert property (rc1_reg[6:5] == 2'h2
        |-> recovered_clock_ratio_o == 10'h200)
        else $error("Ratio code 10 is not 512.");
    hard_mute_a : assert property (rc2_reg[7] && push |-> buf_if.in_data == '0)
        else $error("Hard mute passes audio.");
    err_zero_a : assert property (push && rx_error_i && rc1_reg[3:2] == 2'h2
        |-> buf_if.in_data == '0)
        else $error("Errored sample not replaced by zeros.");
    lock_hold_a : assert property (push && !pll_locked_i && rc1_reg[1:0] == 2'h1
        && !rc2_reg[7] && !(rx_error_i && rc1_reg[3:2] == 2'h2) && gain_reg == 5'h10
        |-> buf_if.in_data == last_good_reg)
        else $error("Unlocked hold does not repeat the last good sample.");
    gate_block_a : assert property (rc2_reg[0] || rc2_reg[1] || rx_compressed_i
        |-> !buf_if.in_valid && rx_ready_o)
        else $error("Gated receiver data reached the buffer.");
    pll_ref_a : assert property (pll_ref_from_serial_port_o == rc2_reg[6]
        && pll_ref_port_select_o == rc2_reg[5:4])
        else $error("PLL reference outputs disagree with the register.");
    deemph_a : assert property (!rc1_reg[4] |-> !deemphasis_apply_o)
        else $error("De-emphasis applied while disabled.");

endmodule // aoscr_top

// [tb/aoscr_host.sv]
// Behavioural host that runs control-port frames.
`timescale 1ns/10ps
module aoscr_host
(
    input  wire logic clk_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Seven address bits, read flag, eight data bits, MSB first; sclk idles low.
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] wd,
                        output logic [7:0] q);
        logic [15:0] f;
        f = {a, rd, wd};
        q = 8'h00;
        @(negedge clk_i) cs_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 15; i >= 0; i--)
        begin
            mosi_o = f[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            if (i < 8)
                q[i] = miso_oe_i ? miso_i : ~miso_i;
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (6) @(negedge clk_i);
    endtask
endmodule // aoscr_host

// [tb/aoscr_top_tb.sv]
// Self-checking bench for the aux output, converter and receiver control slice.
`timescale 1ns/10ps
module aoscr_top_tb;
    import aoscr_pkg::*;
    logic        clk_i = 1'b0, nrst_i = 1'b0, pll_locked_i = 1'b1, cs_emphasis_i = 1'b0;
    logic        rx_valid_i = 1'b0, rx_error_i = 1'b0, rx_compressed_i = 1'b0;
    logic        aud_ready_i = 1'b0, sclk, cs_n, mosi, miso, miso_oe, rx_ready_o, aud_valid_o;
    logic        internal_clock_one, deemph, pref;
    logic [23:0] rx_data_i = 24'h000000, aud_data_o, d, lg;
    logic [1:0]  org, fmt, psel, f;
    logic [4:0]  wsize, gain;
    logic [6:0]  dly;
    logic [9:0]  ratio;
    logic [23:0] expq [$];
    int          n_fail = 0, n_tests = 0, rdy_mode = 0;

    always #12.5 clk_i = ~clk_i;

    aoscr_host u_aoscr_host (.clk_i(clk_i), .miso_i(miso), .miso_oe_i(miso_oe),
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

    aoscr_top u_aoscr_top (.clk_i(clk_i), .nrst_i(nrst_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
        .pll_locked_i(pll_locked_i), .cs_emphasis_i(cs_emphasis_i), .rx_valid_i(rx_valid_i),
        .rx_ready_o(rx_ready_o), .rx_data_i(rx_data_i), .rx_error_i(rx_error_i),
        .rx_compressed_i(rx_compressed_i), .aud_valid_o(aud_valid_o), .aud_ready_i(aud_ready_i),
        .aud_data_o(aud_data_o), .port_clock_origin_o(org), .output_word_size_o(wsize),
        .serial_framing_format_o(fmt), .fir_extra_delay_o(dly), .rx_clock_use_internal_clock_one_o(internal_clock_one),
        .recovered_clock_ratio_o(ratio), .deemphasis_apply_o(deemph),
        .pll_ref_from_serial_port_o(pref), .pll_ref_port_select_o(psel), .converter_gain_o(gain));

    // ==========================================================
    // Compare, bus and sample tasks
    task automatic chk_out(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        chk_out({16'h0000, g}, {16'h0000, e});
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] q;
        u_aoscr_host.xfer(a, 1'b0, v, q);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_aoscr_host.xfer(a, 1'b1, 8'h00, q);
        chk_reg(q, e);
    endtask

    // Offers one sample and notes the expected output word when one should appear.
    task automatic push(input logic [23:0] dv, input logic er, cp, keep, input logic [23:0] e);
        int k;
        k = 0;
        @(negedge clk_i);
        rx_valid_i = 1'b1;
        rx_data_i = dv;
        rx_error_i = er;
        rx_compressed_i = cp;
        while (rx_ready_o !== 1'b1 && k < 200)
        begin
            @(negedge clk_i);
            k++;
        end
        @(posedge clk_i);
        if (keep)
            expq.push_back(e);
        @(negedge clk_i);
        rx_valid_i = 1'b0;
    endtask

    task automatic conclude;
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(negedge clk_i)
        aud_ready_i <= (rdy_mode == 2) | ((rdy_mode == 1) & ($urandom_range(1, 0) == 1));

    always @(posedge clk_i)
        if (aud_valid_o === 1'b1 && aud_ready_i === 1'b1)
            chk_out(aud_data_o,
                    expq.size() != 0 ? expq.pop_front() : 24'hxxxxxx);

    initial
    begin
        #1000000;
        n_fail++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        logic [4:0] wt [4] = '{WORD_24, WORD_20, WORD_18, WORD_16};
        logic [9:0] mt [4] = '{MULT_128, MULT_256, MULT_512, MULT_NONE};
        void'($urandom(99820));
        repeat (4) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        for (int a = 7; a < 11; a++)
            rdc(7'(a), 8'h00);
        chk_out(24'(gain), 24'(GAIN_MAX));
        for (int c = 0; c < 4; c++)
        begin
            f = c[1] ? 2'b11 : 2'(c);
            wr(AUX_OUT_ADDR, {2'b11, 2'(c), 2'(c), f});
            rdc(AUX_OUT_ADDR, {2'b00, 2'(c), 2'(c), f});
            chk_out(24'(org), 24'(c));
            chk_out(24'(wsize), 24'(wt[c]));
            chk_out(24'(fmt), 24'(f));
            pll_locked_i = c[1];
            cs_emphasis_i = 1'($urandom_range(1, 0));
            wr(RX_CFG1_ADDR, {c[0], 2'(c), 5'h10});
            chk_out(24'(ratio), 24'(mt[c]));
            chk_out(24'(internal_clock_one), 24'(c[0] & ~c[1]));
            chk_out(24'(deemph), 24'(cs_emphasis_i));
            wr(RX_CFG2_ADDR, {2'b01, 2'(c), 4'hc});
            rdc(RX_CFG2_ADDR, {2'b01, 2'(c), 4'h0});
            chk_out({21'h0, pref, psel}, {21'h0, 1'b1, 2'(c)});
        end
        cs_emphasis_i = 1'b1;
        wr(RX_CFG1_ADDR, 8'h00);
        chk_out(24'(deemph), 24'h0);
        for (int i = 0; i < 2; i++)
        begin
            d = i ? 24'h00007f : 24'($urandom_range(127, 0));
            wr(DELAY_MUTE_ADDR, d[7:0]);
            rdc(DELAY_MUTE_ADDR, d[7:0]);
            chk_out(24'(dly), d);
        end
        wr(7'h3c, 8'h5a);
        rdc(7'h3c, 8'h00);
        wr(RX_CFG2_ADDR, 8'h00);
        wr(DELAY_MUTE_ADDR, 8'h00);
        pll_locked_i = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            if (i == 2)
            begin
                chk_out(24'(rx_ready_o), 24'h0);
                rdy_mode = 1;
            end
            d = 24'($urandom);
            push(d, 1'b0, 1'b0, 1'b1, d);
        end
        wr(RX_CFG2_ADDR, 8'h80);
        push(24'($urandom), 1'b0, 1'b0, 1'b1, 24'h0);
        wr(RX_CFG2_ADDR, 8'h00);
        wr(RX_CFG1_ADDR, 8'h08);
        push(24'($urandom), 1'b1, 1'b0, 1'b1, 24'h0);
        lg = 24'($urandom);
        push(lg, 1'b0, 1'b0, 1'b1, lg);
        wr(RX_CFG1_ADDR, 8'h04);
        push(24'($urandom), 1'b1, 1'b0, 1'b1, lg);
        wr(RX_CFG1_ADDR, 8'h02);
        pll_locked_i = 1'b0;
        push(24'($urandom), 1'b0, 1'b0, 1'b1, 24'h0);
        wr(RX_CFG1_ADDR, 8'h01);
        push(24'($urandom), 1'b0, 1'b0, 1'b1, lg);
        pll_locked_i = 1'b1;
        wr(RX_CFG1_ADDR, 8'h00);
        for (int g = 0; g < 3; g++)
        begin
            wr(RX_CFG2_ADDR, (g == 2) ? 8'h00 : 8'(g + 1));
            push(24'($urandom), 1'b0, g == 2, 1'b0, 24'h0);
        end
        d = 24'($urandom);
        push(d, 1'b0, 1'b0, 1'b1, d);
        wr(RX_CFG1_ADDR, 8'h03);
        pll_locked_i = 1'b0;
        push(24'($urandom), 1'b0, 1'b0, 1'b1, d);
        chk_out(24'(gain), 24'(GAIN_MAX - 5'h01));
        pll_locked_i = 1'b1;
        wr(RX_CFG1_ADDR, 8'h00);
        lg = 24'(($signed(d) * 32'sh0000000f) >>> 4);
        push(d, 1'b0, 1'b0, 1'b1, lg);
        for (int m = 0; m < 2; m++)
        begin
            wr(DELAY_MUTE_ADDR, m ? 8'h00 : 8'h80);
            for (int i = 1; i <= 16; i++)
            begin
                push((m == 0 && i == 1) ? d : 24'h0, 1'b0, 1'b0, 1'b1,
                     (m == 0 && i == 1) ? d : 24'h0);
                chk_out(24'(gain), m ? 24'(i) : 24'(16 - i));
            end
        end
        rdy_mode = 2;
        for (int k = 0; k < 200 && expq.size() != 0; k++)
            @(negedge clk_i);
        chk_out(24'(expq.size()), 24'h0);
        conclude();
    end
endmodule // aoscr_top_tb
